// >>> dpll_reference_selection_monitor.sv
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
// Contract
// RQ1: References may be 2.048M, 1.544M or 8k.
// RQ2: Roles primary, secondary master or slave.
// RQ3: Always monitor A and B pairs, flag each.
// RQ4: Primary master drives A, locked to primary.
// RQ5: Primary lost: holdover, then use secondary.
// RQ6: Revert to primary unless revert prevention set.
// RQ7: Secondary master drives B locked to A.
// RQ8: A lost: flag software, holdover, then secondary.
// RQ9: Software promotion moves A role onto B.
// RQ10: Slave locks A, else holdover then B.
// RQ11: Output network reference from local references.
// RQ12: Two references received, state picks one.
// RQ13: Frequency code follows selected reference.
// RQ14: Frequency changes need no reset.
// RQ15: Detect mode 10/11 forces primary/secondary.
// RQ16: Mode 00 uses internal monitor losses.
// RQ17: Mode 01 uses external loss pins.
// RQ18: Bus reference passes its clock and frame.
// RQ19: Bus clock period must be 87-157 ns.
// RQ20: Exactly 1024 clocks between frame pulses.
// RQ21: Fail flag clears when signals valid again.
// RQ22: Store frequency alternately every 32 ms.
// RQ23: Both losses set means holdover.
// RQ24: Monitored signals synchronised before measuring.
module dpll_reference_selection_monitor #(
  parameter int FREQ_W = 24,
  parameter int STORE_CYCLES = dpll_ref_pkg::STORE_CYC
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [3:0] local_network_refs_in,
  input wire logic backplane_ref_one_in,
  input wire logic backplane_ref_two_in,
  input wire logic bus_a_clock_in,
  input wire logic bus_a_frame_in,
  input wire logic bus_b_clock_in,
  input wire logic bus_b_frame_in,
  output logic bus_a_clock_out,
  output logic bus_a_clock_oe_out,
  output logic bus_a_frame_out,
  output logic bus_a_frame_oe_out,
  output logic bus_b_clock_out,
  output logic bus_b_clock_oe_out,
  output logic bus_b_frame_out,
  output logic bus_b_frame_oe_out,
  input wire logic primary_loss_pin_in,
  input wire logic secondary_loss_pin_in,
  input wire logic primary_monitor_fail_in,
  input wire logic secondary_monitor_fail_in,
  input wire logic pll_clock_in,
  input wire logic pll_frame_in,
  input wire logic [FREQ_W-1:0] pll_freq_word_in,
  output logic pll_ref_out,
  output logic pll_frame_ref_out,
  output logic [1:0] pll_freq_mode_out,
  output logic pll_holdover_out,
  output logic [FREQ_W-1:0] holdover_word_out,
  output logic network_ref_out,
  output logic fail_a_out,
  output logic fail_b_out
);
  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 12;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  wire [NSYNC-1:0] raw_in = {secondary_loss_pin_in, primary_loss_pin_in, bus_b_frame_in,
    bus_b_clock_in, bus_a_frame_in, bus_a_clock_in, backplane_ref_two_in,
    backplane_ref_one_in, local_network_refs_in};
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in; // [RQ24]
      sync2_reg <= sync1_reg; // [RQ24]
    end
  end
  wire [3:0] lref_s = sync2_reg[3:0];
  wire ref_one_s = sync2_reg[4];
  wire ref_two_s = sync2_reg[5];
  wire [1:0] bclk_s = {sync2_reg[8], sync2_reg[6]};
  wire [1:0] bfrm_s = {sync2_reg[9], sync2_reg[7]};
  wire ploss_pin_s = sync2_reg[10];
  wire sloss_pin_s = sync2_reg[11];

  // ==========================================================
  // Bus clock and frame monitors, index 0 is A and 1 is B
  logic [1:0] fail_w;
  genvar g;
  for (g = 0; g < 2; g++) begin : g_mon
    logic clk_d_reg;
    logic frm_d_reg;
    logic [5:0] per_reg;
    logic [10:0] cnt_reg;
    logic per_fail_reg;
    logic frm_fail_reg;
    wire clk_rise = bclk_s[g] & ~clk_d_reg;
    wire frm_rise = bfrm_s[g] & ~frm_d_reg;
    wire [5:0] per_inc = per_reg + 6'h01;
    wire per_ok = (per_inc >= 6'(dpll_ref_pkg::BUS_MIN_CYC))
      && (per_inc <= 6'(dpll_ref_pkg::BUS_MAX_CYC));
    wire per_over = per_inc > 6'(dpll_ref_pkg::BUS_MAX_CYC);
    wire [10:0] cnt_inc = cnt_reg + 11'h001;
    wire cnt_over = cnt_reg > 11'(dpll_ref_pkg::FRAME_CLOCKS);
    always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
        clk_d_reg <= 1'b0;
        frm_d_reg <= 1'b0;
        per_reg <= 6'h00;
        cnt_reg <= 11'h000;
        per_fail_reg <= 1'b1;
        frm_fail_reg <= 1'b1;
      end else begin
        clk_d_reg <= bclk_s[g];
        frm_d_reg <= bfrm_s[g];
        if (clk_rise) begin
          per_reg <= 6'h00;
          per_fail_reg <= ~per_ok; // [RQ19] [RQ21]
        end else if (per_over) begin
          per_fail_reg <= 1'b1; // [RQ19]
        end else begin
          per_reg <= per_inc;
        end
        if (frm_rise) begin
          cnt_reg <= {10'h000, clk_rise};
          frm_fail_reg <= (cnt_reg != 11'(dpll_ref_pkg::FRAME_CLOCKS)); // [RQ20] [RQ21]
        end else if (cnt_over) begin
          frm_fail_reg <= 1'b1; // [RQ20]
        end else if (clk_rise) begin
          cnt_reg <= cnt_inc;
        end
      end
    end
    assign fail_w[g] = per_fail_reg | frm_fail_reg; // [RQ3]
  end

  // ==========================================================
  // Registers
  logic [12:0] mode_one_reg;
  logic [4:0] mode_two_reg;
  logic a_lost_reg;
  logic ack_reg;
  wire [1:0] pfreq = mode_one_reg[dpll_ref_pkg::PFREQ_LSB +: 2];
  wire [1:0] sfreq = mode_one_reg[dpll_ref_pkg::SFREQ_LSB +: 2];
  wire revert_prevent = mode_one_reg[dpll_ref_pkg::REVERT_BIT];
  wire [2:0] psrc = mode_one_reg[dpll_ref_pkg::PSRC_LSB +: 3];
  wire [2:0] ssrc = mode_one_reg[dpll_ref_pkg::SSRC_LSB +: 3];
  wire [1:0] nsrc = mode_one_reg[dpll_ref_pkg::NSRC_LSB +: 2];
  wire [1:0] role = mode_two_reg[dpll_ref_pkg::ROLE_LSB +: 2];
  wire [1:0] failure_detect_mode = mode_two_reg[dpll_ref_pkg::FDM_LSB +: 2];
  wire promoted = mode_two_reg[dpll_ref_pkg::PROMOTE_BIT];
  wire is_primary = role == dpll_ref_pkg::ROLE_PRIMARY; // [RQ2]
  wire is_secondary = role == dpll_ref_pkg::ROLE_SECONDARY; // [RQ2]

  // ==========================================================
  // Reference muxes
  function automatic logic pick_src(input logic [2:0] s, input logic [3:0] l,
    input logic r1, input logic r2);
    logic v;
    v = 1'b0;
    if (s == dpll_ref_pkg::SRC_REF_ONE) begin
      v = r1;
    end else if (s == dpll_ref_pkg::SRC_REF_TWO) begin
      v = r2;
    end else if (s[2] == 1'b0) begin
      v = l[s[1:0]];
    end
    return v;
  endfunction : pick_src
  wire prim_net = pick_src(psrc, lref_s, ref_one_s, ref_two_s); // [RQ4]
  wire sec_net = pick_src(ssrc, lref_s, ref_one_s, ref_two_s);
  // Outside primary master the primary reference is always the A pair.
  wire prim_is_bus = ~is_primary; // [RQ7] [RQ10]
  wire sec_is_bus = ~is_primary & ~is_secondary; // [RQ10]
  wire primary_reference = prim_is_bus ? bclk_s[0] : prim_net; // [RQ12]
  wire secondary_reference = sec_is_bus ? bclk_s[1] : sec_net; // [RQ12]
  wire prim_frame = bfrm_s[0];
  wire sec_frame = bfrm_s[1];
  wire [1:0] primary_freq_select = prim_is_bus ? dpll_ref_pkg::FREQ_BUS_8M192 : pfreq; // [RQ1]
  wire [1:0] secondary_freq_select = sec_is_bus ? dpll_ref_pkg::FREQ_BUS_8M192 : sfreq; // [RQ1]

  // ==========================================================
  // Loss selection
  wire auto_ploss = prim_is_bus ? fail_w[0] : primary_monitor_fail_in;
  wire auto_sloss = sec_is_bus ? fail_w[1] : secondary_monitor_fail_in;
  wire manual = failure_detect_mode == dpll_ref_pkg::FDM_MANUAL;
  wire primary_loss = manual ? ploss_pin_s : auto_ploss; // [RQ16] [RQ17]
  wire secondary_loss = manual ? sloss_pin_s : auto_sloss; // [RQ16] [RQ17]
  wire force_pri = failure_detect_mode == dpll_ref_pkg::FDM_FORCE_PRI;
  wire force_sec = failure_detect_mode == dpll_ref_pkg::FDM_FORCE_SEC;

  // ==========================================================
  // Selection state machine
  dpll_ref_pkg::sel_state_t state_reg;
  dpll_ref_pkg::sel_state_t state_next;
  always_comb begin
    state_next = state_reg;
    if (force_pri) begin
      state_next = dpll_ref_pkg::ST_PRI; // [RQ15]
    end else if (force_sec) begin
      state_next = dpll_ref_pkg::ST_SEC; // [RQ15]
    end else begin
      case (state_reg)
        dpll_ref_pkg::ST_PRI: begin
          if (primary_loss) begin
            state_next = dpll_ref_pkg::ST_HOLD_PRI; // [RQ5] [RQ8] [RQ10]
          end
        end
        dpll_ref_pkg::ST_HOLD_PRI: begin
          if (!primary_loss) begin
            state_next = dpll_ref_pkg::ST_PRI;
          end else if (!secondary_loss) begin
            state_next = dpll_ref_pkg::ST_SEC; // [RQ5] [RQ8] [RQ10] [RQ23]
          end
        end
        dpll_ref_pkg::ST_SEC: begin
          if (secondary_loss) begin
            state_next = dpll_ref_pkg::ST_HOLD_SEC;
          end else if (!primary_loss && !revert_prevent) begin
            state_next = dpll_ref_pkg::ST_PRI; // [RQ6]
          end
        end
        default: begin
          if (!secondary_loss) begin
            state_next = dpll_ref_pkg::ST_SEC;
          end else if (!primary_loss) begin
            state_next = dpll_ref_pkg::ST_PRI; // [RQ23]
          end
        end
      endcase
    end
  end
  wire on_sec = (state_reg == dpll_ref_pkg::ST_SEC)
    || (state_reg == dpll_ref_pkg::ST_HOLD_SEC);
  wire holdover = (state_reg == dpll_ref_pkg::ST_HOLD_PRI)
    || (state_reg == dpll_ref_pkg::ST_HOLD_SEC); // [RQ23]

  // ==========================================================
  // Holdover storage, two slots written in turn
  logic [31:0] store_cnt_reg;
  logic [FREQ_W-1:0] slot_reg [2];
  logic slot_sel_reg;
  wire store_now = store_cnt_reg == 32'(STORE_CYCLES - 1);
  // The slot due to be written next is the older one, 32 to 64 ms old.
  wire [FREQ_W-1:0] old_word = slot_reg[slot_sel_reg]; // [RQ22]
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      store_cnt_reg <= 32'h0000_0000;
      slot_sel_reg <= 1'b0;
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
      holdover_word_out <= '0;
    end else begin
      if (!holdover) begin
        store_cnt_reg <= store_now ? 32'h0000_0000 : store_cnt_reg + 32'h0000_0001;
        if (store_now) begin
          slot_reg[slot_sel_reg] <= pll_freq_word_in; // [RQ22]
          slot_sel_reg <= ~slot_sel_reg; // [RQ22]
        end
        holdover_word_out <= old_word;
      end
    end
  end

  // ==========================================================
  // Outputs toward the PLL and the bus lines
  wire drive_a = is_primary & ~promoted; // [RQ4]
  wire drive_b = is_secondary | (is_primary & promoted); // [RQ7] [RQ9]
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= dpll_ref_pkg::ST_PRI;
      pll_ref_out <= 1'b0;
      pll_frame_ref_out <= 1'b0;
      pll_freq_mode_out <= dpll_ref_pkg::FREQ_8K;
      pll_holdover_out <= 1'b0;
      network_ref_out <= 1'b0;
      bus_a_clock_out <= 1'b0;
      bus_a_frame_out <= 1'b0;
      bus_b_clock_out <= 1'b0;
      bus_b_frame_out <= 1'b0;
      bus_a_clock_oe_out <= 1'b0;
      bus_a_frame_oe_out <= 1'b0;
      bus_b_clock_oe_out <= 1'b0;
      bus_b_frame_oe_out <= 1'b0;
      fail_a_out <= 1'b1;
      fail_b_out <= 1'b1;
    end else begin
      state_reg <= state_next;
      pll_ref_out <= on_sec ? secondary_reference : primary_reference; // [RQ12] [RQ18]
      pll_frame_ref_out <= on_sec ? sec_frame : prim_frame; // [RQ18]
      // Live field values, so a new frequency acts at once.
      pll_freq_mode_out <= on_sec ? secondary_freq_select : primary_freq_select; // [RQ13] [RQ14]
      pll_holdover_out <= holdover; // [RQ5]
      network_ref_out <= lref_s[nsrc]; // [RQ11]
      bus_a_clock_out <= pll_clock_in;
      bus_a_frame_out <= pll_frame_in;
      bus_b_clock_out <= pll_clock_in; // [RQ7]
      bus_b_frame_out <= pll_frame_in;
      bus_a_clock_oe_out <= drive_a;
      bus_a_frame_oe_out <= drive_a;
      bus_b_clock_oe_out <= drive_b;
      bus_b_frame_oe_out <= drive_b;
      fail_a_out <= fail_w[0]; // [RQ3]
      fail_b_out <= fail_w[1]; // [RQ3]
    end
  end

  // ==========================================================
  // Avalon slave, one wait state per access
  wire req = avs_read_in | avs_write_in;
  wire take = req & ack_reg;
  wire hit_one = avs_address_in == dpll_ref_pkg::ADDR_MODE_ONE;
  wire hit_two = avs_address_in == dpll_ref_pkg::ADDR_MODE_TWO;
  wire hit_st = avs_address_in == dpll_ref_pkg::ADDR_STATUS;
  wire hit_hw = avs_address_in == dpll_ref_pkg::ADDR_HOLD_WORD;
  wire a_lost_clr = take & avs_write_in & hit_st & avs_writedata_in[dpll_ref_pkg::ST_A_LOST];
  wire a_lost_set = is_secondary & primary_loss & ~force_pri & ~force_sec; // [RQ8]
  wire [31:0] status_word = {25'h0000000, secondary_loss, primary_loss, a_lost_reg, on_sec,
    holdover, fail_w[1], fail_w[0]};
  wire [31:0] rd_mux = hit_one ? {19'h00000, mode_one_reg}
    : hit_two ? {27'h0000000, mode_two_reg}
    : hit_st ? status_word
    : hit_hw ? 32'(holdover_word_out)
    : 32'h0000_0000;
  assign avs_waitrequest_out = req & ~ack_reg;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
      mode_one_reg <= dpll_ref_pkg::MODE_ONE_RST;
      mode_two_reg <= dpll_ref_pkg::MODE_TWO_RST;
      a_lost_reg <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      avs_readdata_out <= rd_mux;
      if (take && avs_write_in && hit_one) begin
        mode_one_reg <= avs_writedata_in[12:0];
      end
      if (take && avs_write_in && hit_two) begin
        mode_two_reg <= avs_writedata_in[4:0]; // [RQ2] [RQ9]
      end
      // A new loss in the clearing cycle keeps the flag set.
      a_lost_reg <= a_lost_set | (a_lost_reg & ~a_lost_clr); // [RQ8]
    end
  end
endmodule : dpll_reference_selection_monitor

// >>> dpll_ref_pkg.sv
package dpll_ref_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] ADDR_MODE_ONE = 4'h0;
  localparam logic [3:0] ADDR_MODE_TWO = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_HOLD_WORD = 4'hc;
  // ==========================================================
  // Mode register one fields
  localparam int PFREQ_LSB = 0;
  localparam int SFREQ_LSB = 2;
  localparam int REVERT_BIT = 4;
  localparam int PSRC_LSB = 5;
  localparam int SSRC_LSB = 8;
  localparam int NSRC_LSB = 11;
  localparam logic [12:0] MODE_ONE_RST = 13'h0000;
  // ==========================================================
  // Mode register two fields
  localparam int ROLE_LSB = 0;
  localparam int FDM_LSB = 2;
  localparam int PROMOTE_BIT = 4;
  localparam logic [4:0] MODE_TWO_RST = 5'h00;
  // ==========================================================
  // Status register bits
  localparam int ST_FAIL_A = 0;
  localparam int ST_FAIL_B = 1;
  localparam int ST_HOLDOVER = 2;
  localparam int ST_ON_SEC = 3;
  localparam int ST_A_LOST = 4;
  localparam int ST_PLOSS = 5;
  localparam int ST_SLOSS = 6;
  // ==========================================================
  // Encodings
  localparam logic [1:0] ROLE_SLAVE = 2'h0;
  localparam logic [1:0] ROLE_SECONDARY = 2'h1;
  localparam logic [1:0] ROLE_PRIMARY = 2'h2;
  localparam logic [1:0] FDM_AUTO = 2'h0;
  localparam logic [1:0] FDM_MANUAL = 2'h1;
  localparam logic [1:0] FDM_FORCE_PRI = 2'h2;
  localparam logic [1:0] FDM_FORCE_SEC = 2'h3;
  localparam logic [1:0] FREQ_8K = 2'h0;
  localparam logic [1:0] FREQ_1M544 = 2'h1;
  localparam logic [1:0] FREQ_2M048 = 2'h2;
  localparam logic [1:0] FREQ_BUS_8M192 = 2'h3;
  localparam logic [2:0] SRC_REF_ONE = 3'h4;
  localparam logic [2:0] SRC_REF_TWO = 3'h5;
  typedef enum logic [1:0] {ST_PRI, ST_HOLD_PRI, ST_SEC, ST_HOLD_SEC} sel_state_t;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int BUS_PERIOD_MIN_NS = 87;
  localparam int BUS_PERIOD_MAX_NS = 157;
  localparam int BUS_MIN_CYC = (BUS_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_MAX_CYC = BUS_PERIOD_MAX_NS / CLK_PERIOD_NS;
  localparam int FRAME_CLOCKS = 1024;
  localparam int STORE_PERIOD_MS = 32;
  localparam int STORE_CYC = STORE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
endpackage : dpll_ref_pkg

// >>> bus_pair_model.sv
`timescale 1ns/10ps
// ==========================================================
// Far-side backplane clock and frame source.
module bus_pair_model #(
  parameter real PHASE_NS = 1.3
) (
  input wire logic stop_in,
  input wire logic fast_in,
  output logic clk_out,
  output logic frame_out
);
  int cnt = 0;
  // A stopped source parks its lines low, so the monitor sees a dead clock.
  initial begin
    clk_out = 1'b0;
    frame_out = 1'b0;
    #(PHASE_NS);
    forever begin
      #(fast_in ? 40.0 : 62.5);
      clk_out = !stop_in && !clk_out;
      if (!clk_out) begin
        cnt = (cnt + 1) % 1024;
        frame_out = !stop_in && cnt == 0;
      end
    end
  end
endmodule : bus_pair_model

// >>> dpll_ref_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker.
module dpll_ref_monitor #(
  parameter int FREQ_W = 24
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic bus_a_clock_in,
  input wire logic pll_clock_in,
  input wire logic bus_a_clock_out,
  input wire logic bus_b_clock_out,
  input wire logic bus_a_clock_oe_out,
  input wire logic bus_a_frame_oe_out,
  input wire logic bus_b_clock_oe_out,
  input wire logic bus_b_frame_oe_out,
  input wire logic pll_holdover_out,
  input wire logic [FREQ_W-1:0] holdover_word_out,
  input wire logic fail_a_out,
  input wire logic fail_b_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [5:0] still_reg;
  logic prev_reg;
  // Cycles since the A wire moved.
  always_ff @(posedge core_clk_in) begin
    prev_reg <= bus_a_clock_in;
    if (sys_rst_in || prev_reg != bus_a_clock_in) still_reg <= 6'h00;
    else if (still_reg != 6'h3f) still_reg <= still_reg + 6'h01;
  end
  sequence s_req; $rose(avs_read_in || avs_write_in); endsequence
  sequence s_ans; avs_waitrequest_out ##1 !avs_waitrequest_out; endsequence
  sequence s_hold3; pll_holdover_out [*3]; endsequence
  property p_wait; s_req |-> s_ans; endproperty
  property p_oe_a; bus_a_clock_oe_out == bus_a_frame_oe_out; endproperty
  property p_oe_b; bus_b_clock_oe_out == bus_b_frame_oe_out; endproperty
  property p_oe_excl; !(bus_a_clock_oe_out && bus_b_clock_oe_out); endproperty
  property p_copy_a; bus_a_clock_oe_out |-> bus_a_clock_out == $past(pll_clock_in); endproperty
  property p_copy_b; bus_b_clock_oe_out |-> bus_b_clock_out == $past(pll_clock_in); endproperty
  property p_fail_rst; $fell(sys_rst_in) |-> (fail_a_out && fail_b_out) [*8]; endproperty
  property p_stuck; still_reg == 6'd50 |-> fail_a_out; endproperty
  property p_freeze; s_hold3 |-> $stable(holdover_word_out); endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");
  a_oe_a: assert property (p_oe_a) else $error("A enables differ");
  a_oe_b: assert property (p_oe_b) else $error("B enables differ");
  a_oe_excl: assert property (p_oe_excl) else $error("A and B both driven");
  a_copy_a: assert property (p_copy_a) else $error("A clock not from PLL");
  a_copy_b: assert property (p_copy_b) else $error("B clock not from PLL");
  a_fail_rst: assert property (p_fail_rst) else $error("fail cleared early");
  a_stuck: assert property (p_stuck) else $error("dead A clock not flagged");
  a_freeze: assert property (p_freeze) else $error("word moved in holdover");
endmodule : dpll_ref_monitor

bind dpll_reference_selection_monitor dpll_ref_monitor #(.FREQ_W(FREQ_W)) u_mon (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .bus_a_clock_in(bus_a_clock_in), .pll_clock_in(pll_clock_in),
  .bus_a_clock_out(bus_a_clock_out), .bus_b_clock_out(bus_b_clock_out),
  .bus_a_clock_oe_out(bus_a_clock_oe_out), .bus_a_frame_oe_out(bus_a_frame_oe_out),
  .bus_b_clock_oe_out(bus_b_clock_oe_out), .bus_b_frame_oe_out(bus_b_frame_oe_out),
  .pll_holdover_out(pll_holdover_out), .holdover_word_out(holdover_word_out),
  .fail_a_out(fail_a_out), .fail_b_out(fail_b_out));

// >>> dpll_reference_selection_monitor_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t got %h exp %h", $time, a, e); end end
// ==========================================================
// Testbench.
module dpll_reference_selection_monitor_tb;
  logic core_clk_in = 1'b0, sys_rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0, local_network_refs_in = 4'h0, refs;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, e, m, rq[$], rm[$], pq[$], pm[$];
  logic backplane_ref_one_in = 1'b0, backplane_ref_two_in = 1'b0;
  logic primary_loss_pin_in = 1'b0, secondary_loss_pin_in = 1'b0;
  logic primary_monitor_fail_in = 1'b0, secondary_monitor_fail_in = 1'b0;
  logic pll_clock_in = 1'b0, pll_frame_in = 1'b0, look = 1'b0, stop_a = 1'b0, fast_b = 1'b0;
  logic [15:0] pll_freq_word_in = 16'h0, holdover_word_out, w1;
  logic avs_waitrequest_out, bus_a_clock_out, bus_a_clock_oe_out, bus_a_frame_out;
  logic bus_a_frame_oe_out, bus_b_clock_out, bus_b_clock_oe_out, bus_b_frame_out;
  logic bus_b_frame_oe_out, pll_ref_out, pll_frame_ref_out, pll_holdover_out;
  logic network_ref_out, fail_a_out, fail_b_out, ma_c, ma_f, mb_c, mb_f;
  logic [1:0] pll_freq_mode_out;
  int error_cnt = 0, checks = 0, n;
  localparam logic [3:0] ST = dpll_ref_pkg::ADDR_STATUS;
  localparam logic [1:0] PRIM = dpll_ref_pkg::ROLE_PRIMARY, MAN = dpll_ref_pkg::FDM_MANUAL;
  // Shared bus wires.
  wire bus_a_clock_in = bus_a_clock_oe_out ? bus_a_clock_out : ma_c;
  wire bus_a_frame_in = bus_a_frame_oe_out ? bus_a_frame_out : ma_f;
  wire bus_b_clock_in = bus_b_clock_oe_out ? bus_b_clock_out : mb_c;
  wire bus_b_frame_in = bus_b_frame_oe_out ? bus_b_frame_out : mb_f;
  wire [31:0] obs = {holdover_word_out, 7'h00, fail_a_out, fail_b_out, pll_holdover_out,
    pll_ref_out, pll_freq_mode_out, bus_a_clock_oe_out, bus_b_clock_oe_out, network_ref_out};
  always #2 core_clk_in = ~core_clk_in;
  bus_pair_model u_a (.stop_in(stop_a), .fast_in(1'b0), .clk_out(ma_c),
    .frame_out(ma_f));
  bus_pair_model #(.PHASE_NS(17.9)) u_b (.stop_in(1'b0), .fast_in(fast_b), .clk_out(mb_c),
    .frame_out(mb_f));
  // Short store period for simulation.
  dpll_reference_selection_monitor #(.FREQ_W(16), .STORE_CYCLES(16)) DUT (.core_clk_in,
    .sys_rst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .local_network_refs_in, .backplane_ref_one_in,
    .backplane_ref_two_in, .bus_a_clock_in, .bus_a_frame_in, .bus_b_clock_in, .bus_b_frame_in,
    .bus_a_clock_out, .bus_a_clock_oe_out, .bus_a_frame_out, .bus_a_frame_oe_out,
    .bus_b_clock_out, .bus_b_clock_oe_out, .bus_b_frame_out, .bus_b_frame_oe_out,
    .primary_loss_pin_in, .secondary_loss_pin_in, .primary_monitor_fail_in,
    .secondary_monitor_fail_in, .pll_clock_in, .pll_frame_in, .pll_freq_word_in, .pll_ref_out,
    .pll_frame_ref_out, .pll_freq_mode_out, .pll_holdover_out, .holdover_word_out,
    .network_ref_out, .fail_a_out, .fail_b_out);
  always @(posedge core_clk_in) begin
    pll_clock_in <= 1'($urandom);
    pll_frame_in <= 1'($urandom);
  end
  // ==========================================================
  // Watcher.
  always @(posedge core_clk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && rq.size() > 0) begin
      e = rq.pop_front();
      m = rm.pop_front();
      `CHK(avs_readdata_out & m, e & m)
    end
    if (look === 1'b1 && pq.size() > 0) begin
      e = pq.pop_front();
      m = pm.pop_front();
      `CHK(obs & m, e & m)
    end
  end
  task automatic final_report();
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge core_clk_in); while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge core_clk_in);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k);
    rq.push_back(x);
    rm.push_back(k);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic pexp(input logic [31:0] x, input logic [31:0] k);
    pq.push_back(x);
    pm.push_back(k);
    look <= 1'b1;
    @(posedge core_clk_in);
    look <= 1'b0;
    @(posedge core_clk_in);
  endtask : pexp
  task automatic cfg(input logic [31:0] a, input logic [31:0] b);
    bus(1'b1, dpll_ref_pkg::ADDR_MODE_ONE, a);
    bus(1'b1, dpll_ref_pkg::ADDR_MODE_TWO, b);
    repeat (12) @(posedge core_clk_in);
  endtask : cfg
  task automatic pins(input logic p, input logic s);
    primary_loss_pin_in <= p;
    secondary_loss_pin_in <= s;
    repeat (12) @(posedge core_clk_in);
  endtask : pins
  function automatic logic [31:0] pv(logic h, logic r, logic [1:0] f, logic ao, logic bo);
    return {25'h0, h, r, f, ao, bo, refs[2]};
  endfunction : pv
  // Sources: primary ref 0, secondary ref 1, network ref 2.
  function automatic logic [31:0] m1(logic [1:0] f, logic rv);
    return (32'(f) << dpll_ref_pkg::PFREQ_LSB) | (32'h1 << dpll_ref_pkg::SFREQ_LSB)
      | (32'(rv) << dpll_ref_pkg::REVERT_BIT) | (32'h1 << dpll_ref_pkg::SSRC_LSB)
      | (32'h2 << dpll_ref_pkg::NSRC_LSB);
  endfunction : m1
  function automatic logic [31:0] m2(logic [1:0] r, logic [1:0] d, logic p);
    return 32'(r) | (32'(d) << dpll_ref_pkg::FDM_LSB) | (32'(p) << dpll_ref_pkg::PROMOTE_BIT);
  endfunction : m2
  initial begin
    #380000;
    error_cnt++;
    final_report();
  end
  initial begin
    void'($urandom(32'hdd6d21f7));
    refs = 4'($urandom);
    refs[1] = ~refs[0];
    w1 = 16'($urandom);
    local_network_refs_in <= refs;
    pll_freq_word_in <= w1;
    repeat (10) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(dpll_ref_pkg::ADDR_MODE_ONE, 32'h0, 32'hffffffff);
    rd(dpll_ref_pkg::ADDR_MODE_TWO, 32'h0, 32'hffffffff);
    rd(ST, 32'h3, 32'h3);
    rd(4'h2, 32'h0, 32'hffffffff);
    for (int f = 0; f < 4; f++) begin
      cfg(m1(2'(f), 1'b0), m2(PRIM, MAN, 1'b0));
      pexp(pv(1'b0, refs[0], 2'(f), 1'b1, 1'b0), 32'h7f);
    end
    cfg(m1(2'h2, 1'b0), m2(PRIM, MAN, 1'b0));
    pins(1'b1, 1'b0);
    pexp(pv(1'b0, refs[1], 2'h1, 1'b1, 1'b0), 32'h7f);
    pins(1'b0, 1'b0);
    pexp(pv(1'b0, refs[0], 2'h2, 1'b1, 1'b0), 32'h7f);
    cfg(m1(2'h2, 1'b1), m2(PRIM, MAN, 1'b0));
    pins(1'b1, 1'b0);
    pins(1'b0, 1'b0);
    pexp(pv(1'b0, refs[1], 2'h1, 1'b1, 1'b0), 32'h7f);
    pll_freq_word_in <= ~w1;
    pins(1'b1, 1'b1);
    pexp({w1, 16'h0040}, 32'hffff0040);
    for (int d = 2; d < 4; d++) begin
      cfg(m1(2'h2, 1'b0), m2(PRIM, 2'(d), 1'b0));
      pexp(pv(1'b0, refs[d-2], (d == 3) ? 2'h1 : 2'h2, 1'b1, 1'b0), 32'h7f);
    end
    pins(1'b0, 1'b0);
    cfg(m1(2'h2, 1'b0), m2(PRIM, MAN, 1'b1));
    pexp(32'h2, 32'h6);
    cfg(m1(2'h2, 1'b0), m2(dpll_ref_pkg::ROLE_SECONDARY, MAN, 1'b0));
    pexp(32'h2, 32'h6);
    pins(1'b1, 1'b0);
    rd(ST, 32'h18, 32'h1c);
    pins(1'b0, 1'b0);
    bus(1'b1, ST, 32'h10);
    rd(ST, 32'h0, 32'h10);
    cfg(m1(2'h2, 1'b0), m2(dpll_ref_pkg::ROLE_SLAVE, dpll_ref_pkg::FDM_AUTO, 1'b0));
    for (n = 0; n < 100000 && (fail_a_out !== 1'b0 || fail_b_out !== 1'b0); n++)
      @(posedge core_clk_in);
    pexp(32'h0, 32'h180);
    rd(ST, 32'h0, 32'h0f);
    stop_a <= 1'b1;
    repeat (200) @(posedge core_clk_in);
    rd(ST, 32'h09, 32'h0f);
    fast_b <= 1'b1;
    repeat (300) @(posedge core_clk_in);
    rd(ST, 32'h07, 32'h07);
    final_report();
  end
endmodule : dpll_reference_selection_monitor_tb
